/* shared/rcs_pkg.sv */
// Constants and types for the receive character status and self-test checker
package rcs_pkg;

  // Status codes on the per-character status output
  localparam logic [2:0] ST_NORMAL    = 3'h0;
  localparam logic [2:0] ST_SPECIAL   = 3'h1;
  localparam logic [2:0] ST_BUF_ERR   = 3'h2;
  localparam logic [2:0] ST_FRAMING   = 3'h3;
  localparam logic [2:0] ST_VIOLATION = 3'h4;
  localparam logic [2:0] ST_LOCK_LOST = 3'h5;
  localparam logic [2:0] ST_DISP_ERR  = 3'h6;
  localparam logic [2:0] ST_RESYNC    = 3'h7;

  // Self-test codes, same encoding, checker meanings
  localparam logic [2:0] ST_BT_DATA_OK  = 3'h0;
  localparam logic [2:0] ST_BT_CMD_OK   = 3'h1;
  localparam logic [2:0] ST_BT_END_GOOD = 3'h2;
  localparam logic [2:0] ST_BT_END_BAD  = 3'h4;
  localparam logic [2:0] ST_BT_START    = 3'h5;
  localparam logic [2:0] ST_BT_MISMATCH = 3'h6;
  localparam logic [2:0] ST_BT_WAIT     = 3'h7;

  // Characters substituted onto the output bus (low 8 bits, control flag separate)
  localparam logic [7:0] CHAR_C0_7 = 8'hE0;
  localparam logic [7:0] CHAR_C1_7 = 8'hE1;
  localparam logic [7:0] CHAR_C2_7 = 8'hE2;
  localparam logic [7:0] CHAR_C4_7 = 8'hE4;

  // Bond mode field: independent when 2'b00 (LL) or upper bit set (H)
  localparam logic [1:0] MODE_INDEP_LL = 2'h0;
  localparam logic [1:0] MODE_BONDED   = 2'h1;

  // Framing-machine counts
  localparam logic [2:0] FRAME_RUN_CNT = 3'h4;
  localparam logic [2:0] DEC_ERR_CNT   = 3'h4;
  localparam logic [2:0] BAD_MINUS_OK  = 3'h4;

  // Reset values
  localparam logic [2:0] RST_STATUS = 3'h5;
  localparam logic [7:0] RST_CHAR   = 8'h00;

  typedef enum logic [2:0] {
    FR_HUNT,
    FR_ACQUIRED,
    FR_SYNCED,
    FR_DELIVER
  } rcs_frame_e;

  typedef enum logic [2:0] {
    BT_START,
    BT_WAIT,
    BT_COMPARE
  } rcs_bist_e;

endpackage

/* verilog/rcs_rx_status.sv */
// Receive character status coding, bonded framing machine and self-test checker
`timescale 1ns/100ps

// Overview of operation
// - Bonded: bond failure with deskew expiry, or decoder error, returns hunt to start.
// - Acquired state falls back on buffer error, lock loss, decoder error, bond failure.
// - Advance to synced only after four uninterrupted framing characters.
// - Synced loses sync on buffer error, lock loss, four decoder errors, bad-minus-good 4.
// - Enter delivery on the valid character that follows the last framing character while bonded.
// - Delivery state exits only on buffer under/overrun, PLL lock loss, or independent mode being selected.
// - Independent status coding applies when bond mode selects independent (LL or H).
// - Valid data with correct disparity reports 000.
// - Special code other than framing or violation reports 001.
// - Buffer add/drop failure reports 010 under type A; invalid under type B.
// - Framing character reports 011 and its decoded value goes to the bus.
// - Undecodable character reports 100 and drives C0.7.
// - PLL out of lock reports 101, highest priority.
// - Disparity error reports 110 with C4.7, C1.7 or C2.7 on bus.
// - Self-test reports 000 for good data compare, 001 for good command.
// - Self-test reports 010 for valid final character.
// - Self-test reports 100 for invalid final character.
// - Self-test reports 101 before comparing, on lock loss or buffer error.
// - Self-test reports 110 on compare mismatch.
// - Self-test reports 111 while waiting for start-of-test character.
module rcs_rx_status (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Configuration
  input  wire logic [1:0] rx_bond_mode,
  input  wire logic       status_type_b,
  input  wire logic       selftest_en,
  // Decoded character from the decoder and buffer
  input  wire logic       char_valid,
  input  wire logic [7:0] char_data,
  input  wire logic       char_is_ctrl,
  input  wire logic       framing_char,
  input  wire logic       code_violation,
  input  wire logic       disp_error,
  input  wire logic [7:0] disp_err_char,
  input  wire logic       buf_error,
  input  wire logic       pll_unlocked,
  // Bonding inputs
  input  wire logic       channels_bonded,
  input  wire logic       deskew_expired,
  // Self-test comparator inputs
  input  wire logic       selftest_start_char,
  input  wire logic       selftest_last_char,
  input  wire logic       selftest_match,
  // Outputs to host
  output logic            out_valid,
  output logic [7:0]      out_char,
  output logic            out_ctrl,
  output logic [2:0]      rx_char_status,
  output logic [2:0]      frame_state
);

  typedef struct packed {
    rcs_pkg::rcs_frame_e fr;
    rcs_pkg::rcs_bist_e  bt;
    logic [2:0]          frame_run;
    logic [2:0]          dec_err_run;
    logic [2:0]          bad_minus_ok;
    logic                valid;
    logic [7:0]          chr;
    logic                ctrl;
    logic [2:0]          status;
  } rcs_state_s;

  rcs_state_s st_q;
  rcs_state_s st_d;

  logic indep;
  logic dec_err;
  logic bond_fail;

  // Upper bit set is H, otherwise only LL is independent
  assign indep     = rx_bond_mode[1] || (rx_bond_mode == rcs_pkg::MODE_INDEP_LL);
  assign dec_err   = code_violation || disp_error;
  assign bond_fail = !channels_bonded && deskew_expired;

  always_comb begin
    st_d       = st_q;
    st_d.valid = char_valid;
    if (char_valid) begin
      st_d.chr  = char_data;
      st_d.ctrl = char_is_ctrl;

      // Bonded framing machine
      if (!indep) begin
        case (st_q.fr)
          rcs_pkg::FR_HUNT: begin
            if (bond_fail || dec_err) begin
              st_d.fr = rcs_pkg::FR_HUNT;
            end else if (framing_char) begin
              st_d.fr = rcs_pkg::FR_ACQUIRED;
            end
            st_d.frame_run = framing_char ? 3'h1 : 3'h0;
          end
          rcs_pkg::FR_ACQUIRED: begin
            if (buf_error || pll_unlocked || dec_err || bond_fail) begin
              st_d.fr        = rcs_pkg::FR_HUNT;
              st_d.frame_run = 3'h0;
            end else if (framing_char) begin
              st_d.frame_run = st_q.frame_run + 3'h1;
              if (st_d.frame_run >= rcs_pkg::FRAME_RUN_CNT) begin
                st_d.fr           = rcs_pkg::FR_SYNCED;
                st_d.dec_err_run  = 3'h0;
                st_d.bad_minus_ok = 3'h0;
              end
            end else begin
              // Run broken, keep hunting for four in a row
              st_d.frame_run = 3'h0;
            end
          end
          rcs_pkg::FR_SYNCED: begin
            st_d.dec_err_run = dec_err ? st_q.dec_err_run + 3'h1 : 3'h0;
            if (dec_err) begin
              st_d.bad_minus_ok = st_q.bad_minus_ok + 3'h1;
            end else if (st_q.bad_minus_ok != 3'h0) begin
              st_d.bad_minus_ok = st_q.bad_minus_ok - 3'h1;
            end
            if (buf_error || pll_unlocked ||
                st_d.dec_err_run >= rcs_pkg::DEC_ERR_CNT ||
                st_d.bad_minus_ok >= rcs_pkg::BAD_MINUS_OK) begin
              st_d.fr = rcs_pkg::FR_HUNT;
            end else if (!framing_char && !dec_err && st_q.frame_run != 3'h0 &&
                         channels_bonded) begin
              // Previous character was the last framing character, this one valid
              st_d.fr = rcs_pkg::FR_DELIVER;
            end
            st_d.frame_run = framing_char ? 3'h1 : 3'h0;
          end
          rcs_pkg::FR_DELIVER: begin
            if (buf_error || pll_unlocked) begin
              st_d.fr = rcs_pkg::FR_HUNT;
            end
          end
          default: st_d.fr = rcs_pkg::FR_HUNT;
        endcase
      end else begin
        st_d.fr = rcs_pkg::FR_HUNT;
      end

      // Self-test checker
      if (!selftest_en || pll_unlocked || buf_error) begin
        st_d.bt = rcs_pkg::BT_START;
      end else begin
        case (st_q.bt)
          rcs_pkg::BT_START:   st_d.bt = rcs_pkg::BT_WAIT;
          rcs_pkg::BT_WAIT:    if (selftest_start_char) st_d.bt = rcs_pkg::BT_COMPARE;
          rcs_pkg::BT_COMPARE: st_d.bt = rcs_pkg::BT_COMPARE;
          default:             st_d.bt = rcs_pkg::BT_START;
        endcase
      end

      // Status coding, tests ordered by priority number
      if (selftest_en) begin
        if (st_d.bt == rcs_pkg::BT_START) begin
          st_d.status = rcs_pkg::ST_BT_START;
        end else if (st_d.bt == rcs_pkg::BT_WAIT) begin
          st_d.status = rcs_pkg::ST_BT_WAIT;
        end else if (st_q.bt == rcs_pkg::BT_WAIT) begin
          // Start character just found: first compare result
          st_d.status = char_is_ctrl ? rcs_pkg::ST_BT_CMD_OK : rcs_pkg::ST_BT_DATA_OK;
        end else if (selftest_last_char) begin
          st_d.status = selftest_match ? rcs_pkg::ST_BT_END_GOOD
                                       : rcs_pkg::ST_BT_END_BAD;
        end else if (!selftest_match) begin
          st_d.status = rcs_pkg::ST_BT_MISMATCH;
        end else begin
          st_d.status = char_is_ctrl ? rcs_pkg::ST_BT_CMD_OK : rcs_pkg::ST_BT_DATA_OK;
        end
      end else if (pll_unlocked) begin
        st_d.status = rcs_pkg::ST_LOCK_LOST;
      end else if (buf_error && !status_type_b) begin
        st_d.status = rcs_pkg::ST_BUF_ERR;
      end else if (!indep && st_d.fr != rcs_pkg::FR_DELIVER) begin
        // Bonded and not yet delivering: resync with framing char shown
        st_d.status = rcs_pkg::ST_RESYNC;
      end else if (code_violation) begin
        st_d.status = rcs_pkg::ST_VIOLATION;
        st_d.chr    = rcs_pkg::CHAR_C0_7;
        st_d.ctrl   = 1'b1;
      end else if (framing_char) begin
        st_d.status = rcs_pkg::ST_FRAMING;
      end else if (disp_error) begin
        st_d.status = rcs_pkg::ST_DISP_ERR;
        st_d.chr    = disp_err_char;
        st_d.ctrl   = 1'b1;
      end else if (char_is_ctrl) begin
        st_d.status = rcs_pkg::ST_SPECIAL;
      end else begin
        st_d.status = rcs_pkg::ST_NORMAL;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.fr           <= rcs_pkg::FR_HUNT;
      st_q.bt           <= rcs_pkg::BT_START;
      st_q.frame_run    <= 3'h0;
      st_q.dec_err_run  <= 3'h0;
      st_q.bad_minus_ok <= 3'h0;
      st_q.valid        <= 1'b0;
      st_q.chr          <= rcs_pkg::RST_CHAR;
      st_q.ctrl         <= 1'b0;
      st_q.status       <= rcs_pkg::RST_STATUS;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_valid      = st_q.valid;
  assign out_char       = st_q.chr;
  assign out_ctrl       = st_q.ctrl;
  assign rx_char_status = st_q.status;
  assign frame_state    = st_q.fr;

endmodule

/* tb/rcs_rx_status_properties.sv */
// Port-level assertions for the receive character status block
`timescale 1ns/100ps
module rcs_rx_status_properties (
  input wire logic       core_clk, sys_rst, status_type_b, selftest_en, char_valid,
  input wire logic       char_is_ctrl, framing_char, code_violation, disp_error,
  input wire logic       buf_error, pll_unlocked, channels_bonded, deskew_expired,
  input wire logic       selftest_start_char, selftest_last_char, selftest_match,
  input wire logic       out_valid, out_ctrl,
  input wire logic [1:0] rx_bond_mode,
  input wire logic [7:0] char_data, disp_err_char, out_char,
  input wire logic [2:0] rx_char_status, frame_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Independent coding, no higher-priority fault on this character
  wire logic ind = !selftest_en && rx_bond_mode != rcs_pkg::MODE_BONDED;
  wire logic ok  = char_valid && !pll_unlocked && !buf_error;
  sequence s_clr; selftest_en && char_valid && buf_error; endsequence
  sequence s_nxt; selftest_en && ok && !selftest_start_char; endsequence
  a_lock_first: assert property (char_valid && pll_unlocked |=> rx_char_status == 3'h5)
    else $error("lock loss status wrong");
  a_buf_type_a: assert property (char_valid && !pll_unlocked && buf_error && !status_type_b
    && !selftest_en |=> rx_char_status == 3'h2) else $error("buffer status wrong");
  a_type_b_quiet: assert property (char_valid && status_type_b && !selftest_en
    |=> rx_char_status != 3'h2) else $error("type B showed buffer code");
  a_viol_subst: assert property (ind && ok && code_violation |=> rx_char_status == 3'h4
    && out_char == 8'hE0 && out_ctrl) else $error("violation coding wrong");
  a_frame_value: assert property (ind && ok && framing_char && !code_violation
    |=> rx_char_status == 3'h3 && out_char == $past(char_data)) else $error("framing wrong");
  a_disp_subst: assert property (ind && ok && disp_error && !code_violation && !framing_char
    |=> rx_char_status == 3'h6 && out_char == $past(disp_err_char))
    else $error("disparity coding wrong");
  a_data_plain: assert property (ind && ok && !code_violation && !framing_char && !disp_error
    && !char_is_ctrl |=> out_valid && rx_char_status == 3'h0
    && out_char == $past(char_data)) else $error("plain data wrong");
  a_bist_restart: assert property (s_clr |=> rx_char_status == 3'h5)
    else $error("self-test start code wrong");
  a_selftest_wait_state: assert property (s_clr ##1 s_nxt |=> rx_char_status == 3'h7)
    else $error("self-test wait code wrong");
  a_deliver_hold: assert property (frame_state == 3'h3 && rx_bond_mode == 2'h1
    && !(char_valid && (buf_error || pll_unlocked)) |=> frame_state == 3'h3)
    else $error("delivery left without cause");
  a_acq_drop: assert property (frame_state == 3'h1 && rx_bond_mode == 2'h1 && char_valid
    && code_violation |=> frame_state == 3'h0) else $error("acquired kept on error");
endmodule
bind rcs_rx_status rcs_rx_status_properties i_props (.*);

/* tb/rcs_host_model.sv */
// Host side that takes each character the receiver delivers
`timescale 1ns/100ps
module rcs_host_model (
  input  wire logic core_clk,
  input  wire logic out_valid,
  output int        rx_count
);
  // Never reset, so characters before a mid-run reset still count
  initial rx_count = 0;
  always @(posedge core_clk) if (out_valid) rx_count <= rx_count + 1;
endmodule

/* tb/rcs_rx_status_tb_top.sv */
// Self-checking bench for the receive character status block
`timescale 1ns/100ps
module rcs_rx_status_tb_top;
  logic       core_clk = 0, sys_rst = 1, status_type_b = 0, selftest_en = 0, char_valid = 0;
  logic       char_is_ctrl = 0, framing_char = 0, code_violation = 0, disp_error = 0;
  logic       buf_error = 0, pll_unlocked = 0, channels_bonded = 0, deskew_expired = 0;
  logic       selftest_start_char = 0, selftest_last_char = 0, selftest_match = 0;
  logic [1:0] rx_bond_mode = 2'h0;
  logic [7:0] char_data = 8'h00, disp_err_char = 8'h00, out_char;
  logic       out_valid, out_ctrl;
  logic [2:0] rx_char_status, frame_state;
  int         fail_count = 0, check_count = 0, sent = 0, host_count;
  localparam logic [8:0] K = 9'h100, FR = 9'h080, CV = 9'h040, DE = 9'h020, BE = 9'h010;
  localparam logic [8:0] PU = 9'h008, ST = 9'h004, LA = 9'h002, MT = 9'h001, NO = 9'h000;
  always #2 core_clk = ~core_clk;
  rcs_rx_status i_dut (.*);
  rcs_host_model i_host (.core_clk(core_clk), .out_valid(out_valid), .rx_count(host_count));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Driven at a falling edge; returns one falling edge later with outputs settled
  task automatic put(input logic [7:0] d, input logic [8:0] f);
    char_valid = 1;
    char_data = d;
    {char_is_ctrl, framing_char, code_violation, disp_error, buf_error, pll_unlocked,
     selftest_start_char, selftest_last_char, selftest_match} = f;
    sent++;
    @(negedge core_clk);
  endtask
  task automatic do_reset();
    char_valid = 0;
    @(negedge core_clk);
    sys_rst = 1;
    repeat (3) @(negedge core_clk);
    sys_rst = 0;
  endtask
  task automatic t_indep();
    chk("rst status", rx_char_status, 8'h05);
    put(8'h41, NO);
    chk("data", {rx_char_status, out_char[4:0]}, {3'h0, 5'h01});
    put(8'hBC, K);
    chk("special", rx_char_status, 8'h01);
    rx_bond_mode = 2'h2;
    put(8'h3C, K | FR);
    chk("framing", {rx_char_status, out_char[4:0]}, {3'h3, 5'h1C});
    put(8'h55, FR | CV);
    chk("violation", {rx_char_status, out_char[4:0]}, {3'h4, 5'h00});
    disp_err_char = rcs_pkg::CHAR_C1_7;
    put(8'h66, DE);
    chk("disparity", {rx_char_status, out_char[4:0]}, {3'h6, 5'h01});
    put(8'h77, BE | CV);
    chk("buffer", rx_char_status, 8'h02);
    put(8'h77, PU | BE);
    chk("lock", rx_char_status, 8'h05);
    status_type_b = 1;
    put(8'h12, BE);
    chk("type b", rx_char_status == 3'h2, 8'h00);
  endtask
  task automatic t_bond();
    rx_bond_mode = 2'h1;
    status_type_b = 0;
    channels_bonded = 1;
    do_reset();
    put(8'h3C, FR);
    chk("acquired", frame_state, 8'h01);
    put(8'h00, CV);
    chk("drop", frame_state, 8'h00);
    channels_bonded = 0;
    deskew_expired = 1;
    put(8'h3C, FR);
    chk("bond fail", frame_state, 8'h00);
    channels_bonded = 1;
    deskew_expired = 0;
    repeat (4) put(8'h3C, FR);
    chk("synced", frame_state, 8'h02);
    repeat (3) put(8'h00, CV);
    chk("sync hold", frame_state, 8'h02);
    put(8'h00, CV);
    chk("sync lost", frame_state == 3'h2, 8'h00);
    do_reset();
    repeat (4) put(8'h3C, FR);
    put(8'h41, NO);
    chk("deliver", frame_state, 8'h03);
    put(8'h00, CV);
    chk("deliver hold", {frame_state, rx_char_status}, {2'h0, 3'h3, 3'h4});
    put(8'h00, BE);
    chk("deliver exit", frame_state == 3'h3, 8'h00);
    rx_bond_mode = 2'h0;
    channels_bonded = 0;
  endtask
  task automatic t_bist();
    selftest_en = 1;
    put(8'h00, BE);
    chk("bt start", rx_char_status, 8'h05);
    put(8'h00, NO);
    chk("bt wait", rx_char_status, 8'h07);
    put(8'h11, ST | MT);
    chk("bt data", rx_char_status, 8'h00);
    put(8'hBC, K | MT);
    chk("bt cmd", rx_char_status, 8'h01);
    put(8'h22, NO);
    chk("bt miss", rx_char_status, 8'h06);
    put(8'h33, LA | MT);
    chk("bt good", rx_char_status, 8'h02);
    put(8'h00, PU);
    chk("bt lock", rx_char_status, 8'h05);
    put(8'h00, NO);
    put(8'h01, ST | MT);
    put(8'h02, LA);
    chk("bt bad", rx_char_status, 8'h04);
    selftest_en = 0;
  endtask
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    do_reset();
    t_indep();
    t_bond();
    t_bist();
    char_valid = 0;
    @(negedge core_clk);
    chk("host count", host_count[7:0], sent[7:0]);
    stop_test();
  end
endmodule
